/* scrb_map.svh */
// register map and telegram constants of the sensor configuration bank
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH
`define SCRB_CMD_READ      3'h2
`define SCRB_CMD_WRITE     3'h3
`define SCRB_CMD_PROG      3'h4
`define SCRB_CMD_ERASE     3'h5
`define SCRB_ADR_STORE     4'h0
`define SCRB_ADR_CLAMP_LO  4'h1
`define SCRB_ADR_CLAMP_HI  4'h2
`define SCRB_ADR_QUIES     4'h3
`define SCRB_ADR_GAIN      4'h4
`define SCRB_ADR_MODE      4'h5
`define SCRB_ADR_LOCK      4'h6
`define SCRB_ADR_ADC       4'h7
`define SCRB_ADR_SPARE13   4'h8
`define SCRB_ADR_DAC       4'h9
`define SCRB_ADR_TC        4'hb
`define SCRB_ADR_SPARE0    4'hc
`define SCRB_ADR_DISABLE   4'hf
`define SCRB_DISABLE_KEY   14'h080f
`define SCRB_HEAD_LAST     4'h8
`define SCRB_DATA_LAST     4'he
`define SCRB_SLOT_NONE     4'hf
`define SCRB_SLOT_LOCK     4'h5
`define SCRB_SLOT_SPARE1   4'h6
`define SCRB_SLOT_TC       4'h9
`define SCRB_SLOT_SPARE0   4'ha
`define SCRB_SLOTS         11
`define SCRB_RD_BITS       5'h10
`endif

/* scrb_pkg.sv */
// types shared by the sensor configuration bank
package scrb_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HEAD = 5'h02,
    ST_DATA = 5'h04,
    ST_EXEC = 5'h08,
    ST_TX   = 5'h10
  } scrb_state_t;
  typedef struct packed {
    logic       range_hi;
    logic [3:0] output_kind_select;
    logic [1:0] filter;
    logic [1:0] range_lo;
    logic       unused;
  } scrb_mode_t;
  typedef struct packed {
    logic [1:0] range_grp;
    logic [4:0] linear_term_field;
    logic [2:0] square_term_field;
  } scrb_tc_t;
  typedef struct packed {
    logic sync;
    logic stb;
    logic bit_val;
  } scrb_rx_t;
  typedef struct packed {
    logic stb;
    logic bit_val;
  } scrb_tx_t;
endpackage : scrb_pkg

/* scrb_top.sv */
// telegram decoder and register bank of the programmable sensor
`timescale 1ns/1ps
`include "scrb_map.svh"
module scrb_top (
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_NRST,
  input  wire scrb_pkg::scrb_rx_t I_RX,
  input  wire logic               I_ACT_PULSE,
  input  wire logic [13:0]        I_ADC_READOUT,
  input  wire logic [13:0]        I_DAC_READOUT,
  output scrb_pkg::scrb_tx_t      O_TX,
  output logic [7:0]              O_CLAMP_LOW,
  output logic [8:0]              O_CLAMP_HIGH,
  output logic [10:0]             O_QUIESCENT,
  output logic [13:0]             O_GAIN,
  output scrb_pkg::scrb_mode_t    O_MODE,
  output scrb_pkg::scrb_tc_t      O_TC,
  output logic                    O_ACTIVE,
  output logic                    O_LOCKED
);
  scrb_pkg::scrb_state_t state_reg;
  scrb_pkg::scrb_tx_t    tx_reg;
  logic [3:0]  cnt_reg;
  logic [8:0]  hdr_reg;
  logic [14:0] dat_reg;
  logic [15:0] txs_reg;
  logic [4:0]  txl_reg;
  logic [13:0] ram_reg [0:`SCRB_SLOTS-1];
  logic [13:0] nv_reg  [0:`SCRB_SLOTS-1] = '{default: 14'h0};
  logic [1:0]  gpi_reg;
  logic        boot_reg;
  logic        lock_reg;
  logic        act_reg;
  logic [2:0]  aq_reg;
  logic        alvl_reg;
  logic        arise;
  logic [2:0]  cmd;
  logic [3:0]  adr;
  logic [13:0] wdat;
  logic [3:0]  slot;
  logic [3:0]  sw;
  logic [13:0] rd_data;
  logic        hdr_ok;
  logic        dp_ok;
  logic        is_rd;
  logic        is_wr;
  logic        is_pg;
  logic        is_er;
  logic        slot_v;
  logic        acc_ok;
  logic        fire;

  // register width of each storage slot
  function automatic logic [3:0] slot_w(input logic [3:0] s);
    case (s)
      4'h0:    slot_w = 4'h8;
      4'h1:    slot_w = 4'h9;
      4'h2:    slot_w = 4'hb;
      4'h3:    slot_w = 4'he;
      4'h4:    slot_w = 4'ha;
      4'h5:    slot_w = 4'h2;
      4'h9:    slot_w = 4'ha;
      default: slot_w = 4'hd;
    endcase
  endfunction : slot_w

  // bit reversal for the readout that goes out lsb first
  function automatic logic [13:0] rev14(input logic [13:0] v);
    for (int i = 0; i < 14; i++) begin
      rev14[i] = v[13-i];
    end
  endfunction : rev14

  // header and data fields, parity counts zeros
  assign cmd    = hdr_reg[8:6];
  assign adr    = hdr_reg[4:1];
  assign wdat   = dat_reg[14:1];
  assign hdr_ok = (hdr_reg[5] == ^(~cmd)) && (hdr_reg[0] == ^(~adr));
  assign dp_ok  = dat_reg[0] == ~^(~wdat);
  assign is_rd  = cmd == `SCRB_CMD_READ;
  assign is_wr  = cmd == `SCRB_CMD_WRITE;
  assign is_pg  = cmd == `SCRB_CMD_PROG;
  assign is_er  = cmd == `SCRB_CMD_ERASE;

  // address to storage slot; spare words 1..3 share one address
  always_comb begin
    case (adr)
      `SCRB_ADR_CLAMP_LO, `SCRB_ADR_CLAMP_HI, `SCRB_ADR_QUIES,
      `SCRB_ADR_GAIN, `SCRB_ADR_MODE, `SCRB_ADR_LOCK: slot = adr - 4'h1;
      `SCRB_ADR_SPARE13: slot = `SCRB_SLOT_SPARE1 + {2'h0, gpi_reg};
      `SCRB_ADR_TC:      slot = `SCRB_SLOT_TC;
      `SCRB_ADR_SPARE0:  slot = `SCRB_SLOT_SPARE0;
      default:           slot = `SCRB_SLOT_NONE;
    endcase
  end
  assign slot_v = slot != `SCRB_SLOT_NONE;
  assign sw     = slot_v ? slot_w(slot) : 4'he;

  // acceptance; a locked part refuses every change, readouts refuse writes
  assign acc_ok = hdr_ok && (
    (is_rd && (slot_v || adr == `SCRB_ADR_ADC || adr == `SCRB_ADR_DAC)) ||
    (is_wr && dp_ok && !lock_reg && (slot_v || adr == `SCRB_ADR_DISABLE)) ||
    ((is_pg || is_er) && adr == `SCRB_ADR_STORE && !lock_reg));
  assign fire = (state_reg == scrb_pkg::ST_EXEC) && acc_ok;

  // read value left-aligned at bit 13; output readout reversed
  always_comb begin
    case (adr)
      `SCRB_ADR_ADC: rd_data = I_ADC_READOUT;
      `SCRB_ADR_DAC: rd_data = rev14(I_DAC_READOUT);
      default:       rd_data = slot_v ? ram_reg[slot] << (4'he - sw) : 14'h0;
    endcase
  end

  // telegram sequencer; a sync marker restarts the header during header or data collection
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg <= scrb_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        scrb_pkg::ST_IDLE: begin
          if (I_RX.sync && act_reg && !boot_reg) begin
            state_reg <= scrb_pkg::ST_HEAD;
            cnt_reg   <= 4'h0;
          end
        end
        scrb_pkg::ST_HEAD, scrb_pkg::ST_DATA: begin
          if (I_RX.sync) begin
            state_reg <= scrb_pkg::ST_HEAD;
            cnt_reg   <= 4'h0;
          end else if (I_RX.stb) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (state_reg == scrb_pkg::ST_HEAD && cnt_reg == `SCRB_HEAD_LAST) begin
              cnt_reg   <= 4'h0;
              // only writes carry a data field
              state_reg <= (hdr_reg[7:5] == `SCRB_CMD_WRITE) ? scrb_pkg::ST_DATA
                                                              : scrb_pkg::ST_EXEC;
            end else if (state_reg == scrb_pkg::ST_DATA && cnt_reg == `SCRB_DATA_LAST) begin
              state_reg <= scrb_pkg::ST_EXEC;
            end
          end
        end
        scrb_pkg::ST_EXEC: state_reg <= fire ? scrb_pkg::ST_TX : scrb_pkg::ST_IDLE;
        scrb_pkg::ST_TX:   if (txl_reg == 5'h1) state_reg <= scrb_pkg::ST_IDLE;
        default:           state_reg <= scrb_pkg::ST_IDLE;
      endcase
    end
  end

  // bit collection, msb first
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      hdr_reg <= 9'h0;
      dat_reg <= 15'h0;
    end else if (I_RX.stb && !I_RX.sync) begin
      if (state_reg == scrb_pkg::ST_HEAD) hdr_reg <= {hdr_reg[7:0], I_RX.bit_val};
      if (state_reg == scrb_pkg::ST_DATA) begin
        dat_reg <= {dat_reg[13:0], I_RX.bit_val};
      end
    end
  end

  // answer shifter: acknowledge 0, then data and parity on reads
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      txs_reg <= 16'h0;
      txl_reg <= 5'h0;
      tx_reg  <= '0;
    end else if (fire) begin
      txs_reg <= is_rd ? {1'b0, rd_data, ~^(~rd_data)} : 16'h0;
      txl_reg <= is_rd ? `SCRB_RD_BITS : 5'h1;
      tx_reg  <= '0;
    end else if (txl_reg != 5'h0) begin
      tx_reg.stb     <= 1'b1;
      tx_reg.bit_val <= txs_reg[15];
      txs_reg        <= {txs_reg[14:0], 1'b0};
      txl_reg        <= txl_reg - 5'h1;
    end else begin
      tx_reg <= '0;
    end
  end

  // volatile copies; loaded from the store one cycle after reset release
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < `SCRB_SLOTS; i++) ram_reg[i] <= 14'h0;
    end else if (boot_reg) begin
      for (int i = 0; i < `SCRB_SLOTS; i++) ram_reg[i] <= nv_reg[i];
    end else if (fire && is_wr && slot_v) begin
      ram_reg[slot] <= wdat & (14'h3fff >> (4'he - sw));
    end
  end

  // non-volatile store has no reset so it survives a power cycle;
  // programming only sets bits, so a store needs the erase first
  always_ff @(posedge I_CORE_CLK) begin
    if (fire && is_er) begin
      for (int i = 0; i < `SCRB_SLOTS; i++) nv_reg[i] <= 14'h0;
    end else if (fire && is_pg) begin
      for (int i = 0; i < `SCRB_SLOTS; i++) nv_reg[i] <= nv_reg[i] | ram_reg[i];
    end
  end

  // spare word pointer: word zero restarts the walk over words 1..3
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      gpi_reg <= 2'h0;
    end else if (fire && (is_rd || is_wr)) begin
      if (adr == `SCRB_ADR_SPARE0) gpi_reg <= 2'h0;
      else if (adr == `SCRB_ADR_SPARE13 && gpi_reg != 2'h2) gpi_reg <= gpi_reg + 2'h1;
    end
  end

  // lock only sampled at power-up, writes to it wait for the next one
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      boot_reg <= 1'b1;
      lock_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) lock_reg <= nv_reg[`SCRB_SLOT_LOCK][0];
    end
  end

  // activate pin: three stages, a level counts once stages two and three agree
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      aq_reg   <= 3'h0;
      alvl_reg <= 1'b0;
    end else begin
      aq_reg <= {aq_reg[1:0], I_ACT_PULSE};
      if (aq_reg[1] == aq_reg[2]) alvl_reg <= aq_reg[2];
    end
  end
  assign arise = (aq_reg[1] == aq_reg[2]) && aq_reg[2] && !alvl_reg;

  // active flag; the activate pulse wins over a same-cycle disable
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      act_reg <= 1'b1;
    end else if (arise) begin
      act_reg <= 1'b1;
    end else if (fire && is_wr && adr == `SCRB_ADR_DISABLE && wdat == `SCRB_DISABLE_KEY) begin
      act_reg <= 1'b0;
    end
  end

  // configuration fields straight from the volatile copies; answer, active and lock flags from their own registers
  assign O_TX         = tx_reg;
  assign O_CLAMP_LOW  = ram_reg[0][7:0];
  assign O_CLAMP_HIGH = ram_reg[1][8:0];
  assign O_QUIESCENT  = ram_reg[2][10:0];
  assign O_GAIN       = ram_reg[3];
  assign O_MODE       = scrb_pkg::scrb_mode_t'(ram_reg[4][9:0]);
  assign O_TC         = scrb_pkg::scrb_tc_t'(ram_reg[`SCRB_SLOT_TC][9:0]);
  assign O_ACTIVE     = act_reg;
  assign O_LOCKED     = lock_reg;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_ack;
    tx_reg.stb && !tx_reg.bit_val;
  endsequence
  sequence s_rd;
    fire && is_rd;
  endsequence

  AST_READ_ANSWER: assert property (s_rd |=> ##1 s_ack ##1 tx_reg.stb [*8])
    else $error("read answer not ack plus data");
  AST_WRITE_ACK: assert property (fire && is_wr |=> ##1 s_ack ##1 !tx_reg.stb)
    else $error("write answer not a single ack");
  AST_BAD_CMD: assert property (
    state_reg == scrb_pkg::ST_EXEC && !(is_rd || is_wr || is_pg || is_er) |=> !tx_reg.stb [*2])
    else $error("unknown command answered");
  AST_STORE_ADR: assert property (
    state_reg == scrb_pkg::ST_EXEC && (is_pg || is_er) && adr != 4'h0 |=> ##1 !tx_reg.stb)
    else $error("store with nonzero address answered");
  AST_ERASE_ALL: assert property (
    fire && is_er |=> nv_reg[0] == 14'h0 && nv_reg[10] == 14'h0)
    else $error("erase did not clear store");
  AST_DEACT_KEY: assert property (
    fire && is_wr && adr == 4'hf && wdat == 14'h080f && !arise |=> !act_reg)
    else $error("key did not deactivate");
  AST_DEACT_CAUSE: assert property (
    $fell(act_reg) |-> $past(fire && is_wr && adr == 4'hf && wdat == 14'h080f))
    else $error("deactivated without key");
  AST_ACTIVATE: assert property (arise |=> act_reg)
    else $error("activate pulse ignored");
  AST_LOCK_LATE: assert property (
    fire && is_wr && adr == 4'h6 |=> $stable(lock_reg))
    else $error("lock took effect at once");
  AST_RO_IGNORE: assert property (
    state_reg == scrb_pkg::ST_EXEC && is_wr && (adr == 4'h7 || adr == 4'h9) |=> ##1 !tx_reg.stb)
    else $error("readout write accepted");
  AST_CLAMP_HI: assert property (
    fire && is_wr && adr == 4'h2 |=> O_CLAMP_HIGH == $past(wdat[8:0]))
    else $error("high clamp not stored low-aligned");
  AST_GAIN: assert property (
    fire && is_wr && adr == 4'h4 |=> O_GAIN == $past(wdat))
    else $error("gain not stored");
  AST_MODE_KIND: assert property (
    fire && is_wr && adr == 4'h5 |=> O_MODE.output_kind_select == $past(wdat[8:5]))
    else $error("output kind field misplaced");
  AST_TC_LIN: assert property (
    fire && is_wr && adr == 4'hb |=> O_TC.linear_term_field == $past(wdat[7:3]))
    else $error("linear term field misplaced");
  // the read sequence is combined with the address test by the sequence operator
  AST_CLAMP_ALIGN: assert property (
    (s_rd and (adr == 4'h2)) |=> txs_reg[14:6] == $past(ram_reg[1][8:0]))
    else $error("read not left-aligned");
endmodule : scrb_top

/* scrb_prog_model.sv */
// programmer model: sends supply-line telegrams and gathers the answer bits
`timescale 1ns/1ps
module scrb_prog_model (
  input  wire logic               i_clk,
  output scrb_pkg::scrb_rx_t      o_rx,
  input  wire scrb_pkg::scrb_tx_t i_tx
);
  logic [15:0] ans;
  logic [4:0]  nans;

  // idle supply line: no sync, no strobe
  initial begin
    o_rx = '0;
    ans  = '0;
    nans = '0;
  end

  // one bit per core cycle, strobe held across consecutive bits
  task automatic send_bit(input logic b);
    @(negedge i_clk);
    o_rx.stb     = 1'b1;
    o_rx.bit_val = b;
  endtask : send_bit

  // whole telegram; bad flips the address parity to provoke silence
  task automatic xfer(input logic [2:0] cmd, input logic [3:0] adr,
                      input logic [13:0] dat, input logic bad);
    logic [8:0]  head;
    logic [14:0] body;
    head = {cmd, ~^cmd, adr, (^adr) ^ bad};
    body = {dat, ~^dat};
    @(negedge i_clk);
    o_rx.sync = 1'b1;
    @(negedge i_clk);
    o_rx.sync = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      send_bit(head[i]);
    end
    if (cmd == 3'h3) begin
      for (int i = 14; i >= 0; i--) begin
        send_bit(body[i]);
      end
    end
    @(negedge i_clk);
    o_rx.stb     = 1'b0;
    o_rx.bit_val = ~o_rx.bit_val; // released line must not keep the last bit
    ans  = '0;
    nans = '0;
    // window covers ack plus 15 bits with margin, so the next sync waits for idle
    repeat (30) begin
      @(posedge i_clk);
      #1;
      if (i_tx.stb === 1'b1) begin
        ans  = {ans[14:0], i_tx.bit_val};
        nans = nans + 5'h01;
      end
    end
  endtask : xfer
endmodule : scrb_prog_model

/* sensor_config_register_bank_tb.sv */
// self-checking bench for the sensor configuration register bank
`timescale 1ns/1ps
module sensor_config_register_bank_tb;
  logic                 clk;
  logic                 nrst;
  logic                 act;
  logic [13:0]          adc;
  logic [13:0]          dac;
  scrb_pkg::scrb_rx_t   rx;
  scrb_pkg::scrb_tx_t   tx;
  logic [7:0]           clamp_lo;
  logic [8:0]           clamp_hi;
  logic [10:0]          quies;
  logic [13:0]          gain;
  scrb_pkg::scrb_mode_t mode;
  scrb_pkg::scrb_tc_t   tc;
  logic                 active;
  logic                 locked;
  int                   fail_count = 0;
  int                   num_checks = 0;

  scrb_top u_scrb_top (.I_CORE_CLK(clk), .I_NRST(nrst), .I_RX(rx), .I_ACT_PULSE(act),
    .I_ADC_READOUT(adc), .I_DAC_READOUT(dac), .O_TX(tx), .O_CLAMP_LOW(clamp_lo),
    .O_CLAMP_HIGH(clamp_hi), .O_QUIESCENT(quies), .O_GAIN(gain), .O_MODE(mode),
    .O_TC(tc), .O_ACTIVE(active), .O_LOCKED(locked));
  scrb_prog_model u_scrb_prog_model (.i_clk(clk), .o_rx(rx), .i_tx(tx));

  // 40 MHz core clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // power cycle: reset low for 20 cycles, then let the boot cycle pass
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // one exchange; answer count and bits are always checked
  task automatic xa(input logic [2:0] cmd, input logic [3:0] adr, input logic [13:0] dat,
                    input logic bad, input logic [4:0] n, input logic [15:0] ans);
    u_scrb_prog_model.xfer(cmd, adr, dat, bad);
    chk({11'h0, u_scrb_prog_model.nans}, {11'h0, n});
    chk(u_scrb_prog_model.ans, ans);
  endtask : xa

  task automatic wr(input logic [3:0] adr, input logic [13:0] dat);
    xa(3'h3, adr, dat, 1'b0, 5'h01, 16'h0000);
  endtask : wr

  // read answer: ack 0, left-aligned data, parity set on an even count of zeros
  task automatic rd(input logic [3:0] adr, input logic [13:0] v);
    xa(3'h2, adr, 14'h0000, 1'b0, 5'h10, {1'b0, v, ~^v});
  endtask : rd

  task automatic nak(input logic [2:0] cmd, input logic [3:0] adr, input logic bad);
    xa(cmd, adr, 14'h0001, bad, 5'h00, 16'h0000);
  endtask : nak

  // erase then program, both at address zero
  task automatic store();
    xa(3'h5, 4'h0, 14'h0000, 1'b0, 5'h01, 16'h0000);
    xa(3'h4, 4'h0, 14'h0000, 1'b0, 5'h01, 16'h0000);
  endtask : store

  // hang guard, about twenty times the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    act  = 1'b0;
    adc  = 14'h2345;
    dac  = 14'h0003;
    do_reset();
    chk({15'h0, active}, 16'h0001);
    chk({15'h0, locked}, 16'h0000);
    $display("test reset done");
    wr(4'h2, 14'h3fff);
    chk({7'h0, clamp_hi}, 16'h01ff);
    wr(4'h1, 14'h3f5a);
    chk({8'h0, clamp_lo}, 16'h005a);
    wr(4'h3, 14'h0400);
    chk({5'h0, quies}, 16'h0400);
    wr(4'h4, 14'h2abc);
    chk({2'h0, gain}, 16'h2abc);
    wr(4'h5, 14'h02d6);
    chk({15'h0, mode.range_hi}, 16'h0001);
    chk({12'h0, mode.output_kind_select}, 16'h0006);
    chk({14'h0, mode.filter}, 16'h0002);
    chk({14'h0, mode.range_lo}, 16'h0003);
    wr(4'hb, 14'h03c9);
    chk({14'h0, tc.range_grp}, 16'h0003);
    chk({11'h0, tc.linear_term_field}, 16'h0019);
    chk({13'h0, tc.square_term_field}, 16'h0001);
    store();
    rd(4'h2, 14'h3fe0);
    rd(4'h5, 14'h2d60);
    rd(4'h4, 14'h2abc);
    $display("test formats done");
    rd(4'h7, 14'h2345);
    rd(4'h9, 14'h3000);
    nak(3'h3, 4'h7, 1'b0);
    nak(3'h3, 4'h9, 1'b0);
    rd(4'h9, 14'h3000);
    nak(3'h2, 4'h0, 1'b0);
    nak(3'h3, 4'h2, 1'b1);
    nak(3'h5, 4'h1, 1'b0);
    nak(3'h7, 4'h1, 1'b0);
    chk({7'h0, clamp_hi}, 16'h01ff);
    $display("test readout and refusal done");
    wr(4'h1, 14'h0011);
    do_reset();
    chk({8'h0, clamp_lo}, 16'h005a);
    chk({2'h0, gain}, 16'h2abc);
    $display("test store done");
    wr(4'hc, 14'h1aaa);
    wr(4'h8, 14'h0111);
    wr(4'h8, 14'h0222);
    wr(4'h8, 14'h0333);
    store();
    rd(4'hc, 14'h3554);
    rd(4'h8, 14'h0222);
    rd(4'h8, 14'h0444);
    rd(4'h8, 14'h0666);
    $display("test spare words done");
    wr(4'hf, 14'h080e);
    chk({15'h0, active}, 16'h0001);
    wr(4'hf, 14'h080f);
    chk({15'h0, active}, 16'h0000);
    nak(3'h2, 4'h2, 1'b0);
    @(negedge clk);
    act = 1'b1;
    repeat (3) @(negedge clk);
    act = 1'b0;
    repeat (6) @(negedge clk);
    chk({15'h0, active}, 16'h0001);
    rd(4'h2, 14'h3fe0);
    $display("test deactivate done");
    wr(4'h6, 14'h0001);
    store();
    chk({15'h0, locked}, 16'h0000);
    do_reset();
    chk({15'h0, locked}, 16'h0001);
    nak(3'h3, 4'h2, 1'b0);
    nak(3'h5, 4'h0, 1'b0);
    nak(3'h4, 4'h0, 1'b0);
    rd(4'h6, 14'h1000);
    chk({7'h0, clamp_hi}, 16'h01ff);
    $display("test lock done");
    final_report();
  end
endmodule : sensor_config_register_bank_tb
